// >>> common/fspc_defs.svh
// constants of the flash sector protect command logic
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define FSPC_OP_WREN      8'h06
`define FSPC_OP_MASK_SET  8'ha8
`define FSPC_OP_MASK_CLR  8'ha9
`define FSPC_OP_VOL_LOCK  8'h7e
`define FSPC_OP_VOL_FREE  8'h98
`define FSPC_OP_PW_READ   8'h27
`define FSPC_OP_PW_WRITE  8'h28
`define FSPC_OP_PW_UNLOCK 8'h29

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define FSPC_NSECT        8
`define FSPC_PW_BITS      64
`define FSPC_OP_BITS      7'd8
`define FSPC_LONG_BITS    7'd72
`define FSPC_PW_RESET     64'hffff_ffff_ffff_ffff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSPC_CLK_NS       50
`define FSPC_UNLOCK_NS    2000
`define FSPC_UNLOCK_CYC   (`FSPC_UNLOCK_NS / `FSPC_CLK_NS)
`define FSPC_HALF_CYC     3'd4

// ----------------------------------------------------------------
// host register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSPC_REG_CMD      8'h00
`define FSPC_REG_PW_HI    8'h04
`define FSPC_REG_PW_LO    8'h08
`define FSPC_CMD_BUSY_BIT 8

`endif

// >>> common/fspc_pkg.sv
// types of the flash sector protect command logic
package fspc_pkg;

    typedef enum logic [1:0] {
        DV_IDLE,
        DV_SHIFT,
        DV_BUSY
    } fspc_dev_st_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_LOW,
        H_HIGH,
        H_END,
        H_GAP
    } fspc_host_st_t;

    typedef struct packed {
        fspc_dev_st_t st;
        logic [63:0]  sr;
        logic [6:0]   cnt;
        logic [7:0]   op;
        logic         cs_prev;
        logic         sclk_prev;
        logic         miso;
        logic         miso_oe;
        logic [63:0]  pw;
        logic         write_latch_flag;
        logic         write_in_progress_flag;
        logic         lock;
        logic         mask;
        logic         match;
        logic [5:0]   tmr;
        logic [7:0]   vol;
        logic [7:0]   prot;
    } fspc_dev_t;

    typedef struct packed {
        fspc_host_st_t st;
        logic [2:0]    div;
        logic [6:0]    left;
        logic [71:0]   tx;
        logic [63:0]   rx;
        logic [7:0]    op;
        logic [31:0]   pw_hi;
        logic [31:0]   pw_lo;
        logic          cs_n;
        logic          sclk;
        logic          mosi;
        logic          ack;
        logic [31:0]   dat;
    } fspc_host_t;

endpackage

// >>> common/fspc_if.sv
// serial link between the protect command host and device
`timescale 1ns/1ps
interface fspc_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // idle line floats high
    assign miso = miso_oe ? miso_o : 1'b1;

    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input  miso
    );
    modport dev (
        input  cs_n,
        input  sclk,
        input  mosi,
        output miso_o,
        output miso_oe
    );
endinterface

// >>> hdl/fspc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fspc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // pins and synchronised copy
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fspc_sync_t;

    fspc_sync_t s_q;
    fspc_sync_t s_d;

    always_comb begin
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
    end

    // reset loads every stage high, the idle level of cs_n and miso (sclk and mosi idle low)
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.s2;
endmodule

// >>> hdl/fspc_dev.sv
// device end: protection commands of the serial flash
`timescale 1ns/1ps
`include "fspc_defs.svh"
module fspc_dev (
    // clock and reset
    input  wire logic                    SYS_CLK,
    input  wire logic                    RESETN,
    // serial link
    fspc_if.dev                          LINK,
    // protection mode strap: one selects password mode
    input  wire logic                    PASSWORD_MODE,
    // nonvolatile protect bits from the array
    input  wire logic [`FSPC_NSECT-1:0]  NV_PROTECT,
    // protection state
    output logic                         SOLID_MASK,
    output logic                         PROTECT_LOCK,
    output logic                         WRITE_LATCH,
    output logic                         WRITE_IN_PROGRESS,
    output logic [`FSPC_NSECT-1:0]       VOL_PROTECT,
    output logic [`FSPC_NSECT-1:0]       SECTOR_PROTECTED
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_single(input logic [7:0] op);
        return op == `FSPC_OP_WREN || op == `FSPC_OP_MASK_SET
            || op == `FSPC_OP_MASK_CLR || op == `FSPC_OP_VOL_LOCK
            || op == `FSPC_OP_VOL_FREE;
    endfunction

    function automatic logic is_long(input logic [7:0] op);
        return op == `FSPC_OP_PW_WRITE || op == `FSPC_OP_PW_UNLOCK;
    endfunction

    localparam logic [5:0] UNLOCK_LAST = 6'(`FSPC_UNLOCK_CYC - 1);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic       mosi_s;

    fspc_sync #(
        .W (3)
    ) u_sync (
        .clk    (SYS_CLK),
        .resetn (RESETN),
        .din    ({LINK.cs_n, LINK.sclk, LINK.mosi}),
        .dout   (pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fspc_pkg::fspc_dev_t s_q;
    fspc_pkg::fspc_dev_t s_d;

    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic       mask_ok;
    logic [6:0] out_idx;

    assign sclk_rise = sclk_s && !s_q.sclk_prev;
    assign sclk_fall = !sclk_s && s_q.sclk_prev;
    assign cs_fall   = !cs_n_s && s_q.cs_prev;
    assign cs_rise   = cs_n_s && !s_q.cs_prev;
    // mask is free in solid mode, needs the lock in password mode
    assign mask_ok   = !PASSWORD_MODE || s_q.lock;
    assign out_idx   = 7'd71 - s_q.cnt;

    always_comb begin
        s_d           = s_q;
        s_d.cs_prev   = cs_n_s;
        s_d.sclk_prev = sclk_s;

        case (s_q.st)
            fspc_pkg::DV_IDLE: begin
                if (cs_fall) begin
                    s_d.st  = fspc_pkg::DV_SHIFT;
                    s_d.cnt = 7'd0;
                    s_d.sr  = '0;
                end
            end

            fspc_pkg::DV_SHIFT: begin
                // opcode and payload sampled on rising clock
                if (sclk_rise && !cs_n_s) begin
                    s_d.sr = {s_q.sr[62:0], mosi_s};
                    if (s_q.cnt != 7'h7f) begin
                        s_d.cnt = s_q.cnt + 7'd1;
                    end
                    if (s_q.cnt == 7'd7) begin
                        s_d.op = {s_q.sr[6:0], mosi_s};
                    end
                end
                // password read-out on falling clock, msb first
                if (sclk_fall && !cs_n_s && s_q.op == `FSPC_OP_PW_READ
                    && s_q.cnt >= `FSPC_OP_BITS) begin
                    s_d.miso_oe = 1'b1;
                    if (s_q.cnt <= 7'd71) begin
                        s_d.miso = s_q.pw[out_idx[5:0]];
                    end else begin
                        s_d.miso = 1'b0;
                    end
                end
                if (cs_rise) begin
                    s_d.st      = fspc_pkg::DV_IDLE;
                    s_d.miso_oe = 1'b0;
                    s_d.miso    = 1'b0;
                    // frames of the wrong length are dropped whole
                    if (s_q.cnt == `FSPC_OP_BITS
                        && is_single(s_q.op)) begin
                        if (s_q.op == `FSPC_OP_WREN) begin
                            s_d.write_latch_flag = 1'b1;
                        end else if (s_q.write_latch_flag) begin
                            case (s_q.op)
                                `FSPC_OP_MASK_SET: begin
                                    if (mask_ok) begin
                                        s_d.mask = 1'b1;
                                    end
                                end
                                `FSPC_OP_MASK_CLR: begin
                                    if (mask_ok) begin
                                        s_d.mask = 1'b0;
                                    end
                                end
                                `FSPC_OP_VOL_LOCK: begin
                                    s_d.vol = '1;
                                end
                                `FSPC_OP_VOL_FREE: begin
                                    s_d.vol = '0;
                                end
                                default: begin
                                end
                            endcase
                            s_d.write_latch_flag = 1'b0;
                        end
                    end else if (s_q.cnt == `FSPC_LONG_BITS
                                 && is_long(s_q.op) && s_q.write_latch_flag) begin
                        s_d.write_latch_flag = 1'b0;
                        if (s_q.op == `FSPC_OP_PW_WRITE) begin
                            s_d.pw = s_q.sr;
                        end else begin
                            // compare now, apply after the unlock time
                            s_d.match = (s_q.sr == s_q.pw);
                            s_d.write_in_progress_flag   = 1'b1;
                            s_d.tmr   = 6'd0;
                            s_d.st    = fspc_pkg::DV_BUSY;
                        end
                    end
                end
            end

            fspc_pkg::DV_BUSY: begin
                // link is ignored until the unlock has finished
                if (s_q.tmr == UNLOCK_LAST) begin
                    s_d.write_in_progress_flag = 1'b0;
                    // a wrong password leaves the lock as it was
                    if (s_q.match) begin
                        s_d.lock = 1'b1;
                    end
                    s_d.st = cs_n_s ? fspc_pkg::DV_IDLE
                                    : fspc_pkg::DV_BUSY;
                end else begin
                    s_d.tmr = s_q.tmr + 6'd1;
                end
            end

            default: begin
                s_d.st = fspc_pkg::DV_IDLE;
            end
        endcase

        // masked nonvolatile bits drop out, volatile bits always count
        s_d.prot = s_q.vol | (NV_PROTECT & {`FSPC_NSECT{s_q.mask}});
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            s_q           <= '0;
            s_q.st        <= fspc_pkg::DV_IDLE;
            s_q.cs_prev   <= 1'b1;
            s_q.sclk_prev <= 1'b1;
            s_q.pw        <= `FSPC_PW_RESET;
            s_q.mask      <= 1'b1;
            s_q.vol       <= '1;
            s_q.prot      <= '1;
            // lock follows the mode: set in solid, clear in password
            s_q.lock      <= !PASSWORD_MODE;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LINK.miso_o       = s_q.miso;
    assign LINK.miso_oe      = s_q.miso_oe;
    assign SOLID_MASK        = s_q.mask;
    // nonvolatile program and erase are allowed only with the lock set
    assign PROTECT_LOCK      = s_q.lock;
    assign WRITE_LATCH       = s_q.write_latch_flag;
    assign WRITE_IN_PROGRESS = s_q.write_in_progress_flag;
    assign VOL_PROTECT       = s_q.vol;
    assign SECTOR_PROTECTED  = s_q.prot;
endmodule

// >>> hdl/fspc_host.sv
// host end: wishbone-driven serial command engine
`timescale 1ns/1ps
`include "fspc_defs.svh"
module fspc_host (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    // wishbone classic slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // serial link
    fspc_if.host             LINK
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lanes(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic miso_s;

    fspc_sync #(
        .W (1)
    ) u_sync (
        .clk    (SYS_CLK),
        .resetn (RESETN),
        .din    (LINK.miso),
        .dout   (miso_s)
    );

    fspc_pkg::fspc_host_t s_q;
    fspc_pkg::fspc_host_t s_d;

    logic req;
    logic half;
    logic busy;
    logic op_long;

    assign req     = WB_CYC_I && WB_STB_I && !s_q.ack;
    assign half    = s_q.div == `FSPC_HALF_CYC - 3'd1;
    assign busy    = s_q.st != fspc_pkg::H_IDLE;
    assign op_long = WB_DAT_I[7:0] == `FSPC_OP_PW_READ
                  || WB_DAT_I[7:0] == `FSPC_OP_PW_WRITE
                  || WB_DAT_I[7:0] == `FSPC_OP_PW_UNLOCK;

    always_comb begin
        s_d     = s_q;
        s_d.ack = req;
        s_d.div = half ? 3'd0 : s_q.div + 3'd1;

        // ------------------------------------------------------------
        // register access, answered one cycle after the request
        // ------------------------------------------------------------
        if (req) begin
            s_d.dat = 32'h0000_0000;
            case (WB_ADR_I)
                `FSPC_REG_CMD: begin
                    s_d.dat[7:0]               = s_q.op;
                    s_d.dat[`FSPC_CMD_BUSY_BIT] = busy;
                    // a start while busy is dropped
                    if (WB_WE_I && WB_SEL_I[0] && !busy) begin
                        s_d.op   = WB_DAT_I[7:0];
                        s_d.tx   = {WB_DAT_I[7:0], s_q.pw_hi, s_q.pw_lo};
                        // single opcodes carry no payload
                        s_d.left = op_long ? `FSPC_LONG_BITS
                                           : `FSPC_OP_BITS;
                        s_d.cs_n = 1'b0;
                        s_d.sclk = 1'b0;
                        s_d.mosi = WB_DAT_I[7];
                        s_d.div  = 3'd0;
                        s_d.st   = fspc_pkg::H_LOW;
                    end
                end
                `FSPC_REG_PW_HI: begin
                    s_d.dat = s_q.rx[63:32];
                    if (WB_WE_I) begin
                        s_d.pw_hi = lanes(s_q.pw_hi, WB_DAT_I, WB_SEL_I);
                    end
                end
                `FSPC_REG_PW_LO: begin
                    s_d.dat = s_q.rx[31:0];
                    if (WB_WE_I) begin
                        s_d.pw_lo = lanes(s_q.pw_lo, WB_DAT_I, WB_SEL_I);
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // serial engine, mode 0, msb first
        // ------------------------------------------------------------
        case (s_q.st)
            fspc_pkg::H_IDLE: begin
            end
            fspc_pkg::H_LOW: begin
                if (half) begin
                    s_d.sclk = 1'b1;
                    s_d.st   = fspc_pkg::H_HIGH;
                end
            end
            fspc_pkg::H_HIGH: begin
                // sample late: the device answers several cycles after
                if (half) begin
                    s_d.sclk = 1'b0;
                    s_d.rx   = {s_q.rx[62:0], miso_s};
                    s_d.tx   = {s_q.tx[70:0], 1'b0};
                    s_d.mosi = s_q.tx[70];
                    s_d.left = s_q.left - 7'd1;
                    s_d.st   = (s_q.left == 7'd1) ? fspc_pkg::H_END
                                                   : fspc_pkg::H_LOW;
                end
            end
            fspc_pkg::H_END: begin
                if (half) begin
                    s_d.cs_n = 1'b1;
                    s_d.mosi = 1'b0;
                    s_d.st   = fspc_pkg::H_GAP;
                end
            end
            fspc_pkg::H_GAP: begin
                if (half) begin
                    s_d.st = fspc_pkg::H_IDLE;
                end
            end
            default: begin
                s_d.st = fspc_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            s_q      <= '0;
            s_q.st   <= fspc_pkg::H_IDLE;
            s_q.cs_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_DAT_O  = s_q.dat;
    assign WB_ACK_O  = s_q.ack;
    assign LINK.cs_n = s_q.cs_n;
    assign LINK.sclk = s_q.sclk;
    assign LINK.mosi = s_q.mosi;
endmodule

// >>> bench/fspc_assertions.sv
// link and state assertions of the protect command logic
`timescale 1ns/1ps
module fspc_assertions (
    // clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RESETN,
    // link
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       mosi,
    input wire logic       miso_oe,
    // device state
    input wire logic       SOLID_MASK,
    input wire logic       PROTECT_LOCK,
    input wire logic       WRITE_LATCH,
    input wire logic       WRITE_IN_PROGRESS,
    input wire logic [7:0] NV_PROTECT,
    input wire logic [7:0] VOL_PROTECT,
    input wire logic [7:0] SECTOR_PROTECTED
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    chk_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("serial clock active while deselected");
    chk_sclk_high: assert property (
        $rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    chk_mosi_hold: assert property (sclk |-> $stable(mosi))
        else $error("host data moved while clock high");
    // sync stages delay the release, so allow six cycles
    chk_miso_free: assert property (cs_n [*6] |-> !miso_oe)
        else $error("device drives data while deselected");
    chk_busy_len: assert property (
        $rose(WRITE_IN_PROGRESS) |-> WRITE_IN_PROGRESS [*8]
        ##32 WRITE_IN_PROGRESS ##1 !WRITE_IN_PROGRESS)
        else $error("unlock busy not forty cycles");
    chk_lock_unlock: assert property (
        $rose(PROTECT_LOCK) |-> WRITE_IN_PROGRESS ||
        $past(WRITE_IN_PROGRESS) || $past(WRITE_IN_PROGRESS, 2))
        else $error("lock set outside an unlock");
    chk_sect_prot: assert property (
        SECTOR_PROTECTED ==
        $past(VOL_PROTECT | (NV_PROTECT & {8{SOLID_MASK}})))
        else $error("sector protection wrong");
    chk_vol_gate: assert property (
        $changed(VOL_PROTECT) |-> $past(WRITE_LATCH))
        else $error("volatile bits changed without latch");
    chk_mask_gate: assert property (
        $changed(SOLID_MASK) |->
        $past(WRITE_LATCH) && $past(PROTECT_LOCK))
        else $error("mask changed without latch or lock");
    chk_latch_end: assert property ($fell(WRITE_LATCH) |-> cs_n)
        else $error("latch cleared inside a frame");
endmodule

// >>> bench/testbench.sv
// self-checking bench for both ends of the protect command link
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        rstn;
    logic        cyc;
    logic        we;
    logic        pmode;
    logic        ack;
    logic        mask;
    logic        lock;
    logic        write_latch_flag;
    logic        write_in_progress_flag;
    logic [7:0]  adr;
    logic [7:0]  nv;
    logic [7:0]  vol;
    logic [7:0]  prot;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic [63:0] p;
    logic [63:0] m_pw;
    logic [7:0]  m_vol;
    logic        m_mask;
    logic        m_lock;
    int          n_errors;
    int          cmp_count;
    logic [7:0]  ops [6] = '{8'ha9, 8'h98, 8'ha8, 8'h7e, 8'ha9, 8'ha8};

    fspc_if link ();
    fspc_host fspc_host_i (.SYS_CLK(clk), .RESETN(rstn),
        .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .LINK(link.host));
    fspc_dev fspc_dev_i (.SYS_CLK(clk), .RESETN(rstn), .LINK(link.dev),
        .PASSWORD_MODE(pmode), .NV_PROTECT(nv), .SOLID_MASK(mask),
        .PROTECT_LOCK(lock), .WRITE_LATCH(write_latch_flag), .WRITE_IN_PROGRESS(write_in_progress_flag),
        .VOL_PROTECT(vol), .SECTOR_PROTECTED(prot));
    fspc_assertions chk_i (.SYS_CLK(clk), .RESETN(rstn),
        .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
        .miso_oe(link.miso_oe), .SOLID_MASK(mask), .PROTECT_LOCK(lock),
        .WRITE_LATCH(write_latch_flag), .WRITE_IN_PROGRESS(write_in_progress_flag), .NV_PROTECT(nv),
        .VOL_PROTECT(vol), .SECTOR_PROTECTED(prot));

    // ----------------------------------------
    // clock, checks and bus cycles
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tmo();
        n_errors++;
        test_done();
    endtask

    task automatic check(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // ack and read data are taken at the edge that shows ack high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rq = rdat;
        cyc <= 1'b0;
        if (n >= 50) tmo();
        @(posedge clk);
    endtask

    task automatic frame(input logic [7:0] op);
        int n;
        n = 0;
        wb(1'b1, 8'h00, {24'h0, op});
        rq = 32'h100;
        while (rq[8] !== 1'b0 && n < 400) begin
            wb(1'b0, 8'h00, 32'h0);
            n++;
        end
        if (n >= 400) tmo();
        repeat (6) @(posedge clk);
    endtask

    task automatic st();
        check(64'({mask, lock, write_latch_flag, write_in_progress_flag, vol, prot}),
              64'({m_mask, m_lock, 2'b00, m_vol,
                   m_vol | (nv & {8{m_mask}})}));
    endtask

    task automatic cmd(input logic [7:0] op, input logic [63:0] d);
        int n;
        int k;
        n = 0;
        k = 0;
        nv <= 8'($urandom);
        wb(1'b1, 8'h04, d[63:32]);
        wb(1'b1, 8'h08, d[31:0]);
        frame(8'h06);
        check(64'(write_latch_flag), 64'h1);
        if (op == 8'h29) begin
            wb(1'b1, 8'h00, {24'h0, op});
            while (write_in_progress_flag !== 1'b1 && n < 700) begin
                @(posedge clk);
                n++;
            end
            if (n >= 700) tmo();
            while (write_in_progress_flag === 1'b1 && k < 80) begin
                @(posedge clk);
                k++;
            end
            check(64'(k), 64'd40);
            repeat (6) @(posedge clk);
        end else begin
            frame(op);
        end
        case (op)
            8'ha8: if (m_lock) m_mask = 1'b1;
            8'ha9: if (m_lock) m_mask = 1'b0;
            8'h7e: m_vol = 8'hff;
            8'h98: m_vol = 8'h00;
            8'h28: m_pw = d;
            8'h29: if (d == m_pw) m_lock = 1'b1;
            default: ;
        endcase
        st();
    endtask

    task automatic pw_read();
        logic [31:0] hi;
        frame(8'h27);
        wb(1'b0, 8'h04, 32'h0);
        hi = rq;
        wb(1'b0, 8'h08, 32'h0);
        check({hi, rq}, m_pw);
    endtask

    task automatic reset(input logic pm);
        rstn <= 1'b0;
        pmode <= pm;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        m_mask = 1'b1;
        m_vol = 8'hff;
        m_lock = !pm;
        m_pw = '1;
        repeat (4) @(posedge clk);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        pmode = 1'b0;
        nv = 8'h00;
        n_errors = 0;
        cmp_count = 0;
        void'($urandom(77570));
        reset(1'b0);
        st();
        wb(1'b0, 8'h0c, 32'h0);
        check(64'(rq), 64'h0);
        pw_read();
        $display("end test reset");
        nv <= 8'($urandom);
        frame(8'h98);
        repeat (2) @(posedge clk);
        st();
        $display("end test no latch");
        foreach (ops[i]) cmd(ops[i], 64'h0);
        $display("end test commands");
        p = {$urandom, $urandom};
        cmd(8'h28, p);
        pw_read();
        $display("end test password");
        reset(1'b1);
        st();
        cmd(8'ha9, 64'h0);
        cmd(8'h29, p & ~64'h1);
        cmd(8'h29, '1);
        cmd(8'ha9, 64'h0);
        cmd(8'ha8, 64'h0);
        $display("end test password mode");
        test_done();
    end
endmodule
